// ===== verif/idc_dom_model.sv
`timescale 1ns/1ps
module idc_dom_model #(
  parameter int N = 9
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic [N-1:0] req_i,
  output logic [N-1:0] ack_o
);
  logic [N-1:0] dly_q;
  // stop acknowledged late
  // Slow mode acks a cycle later, like a domain that drains first
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      dly_q <= '0;
      ack_o <= '0;
    end else begin
      dly_q <= req_i;
      ack_o <= slow_i ? (dly_q & req_i) : req_i;
    end
  end
endmodule

// ===== verif/idle_domain_controller_tb_top.sv
`timescale 1ns/1ps
module idle_domain_controller_tb_top;
  import idc_pkg::*;
  logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, idle_exec_i = 0, wake_i = 0, slow = 0;
  logic ce_i = 1;
  logic [15:0] addr_i = '0, wdata_i = '0, rdata_o;
  logic [IDC_NDOM-1:0] idle_req_o, idle_ack_i;
  logic [13:0] periph_idle_req_o;
  logic bus_err_o;
  int bad_count = 0, comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  idc_ctrl i_idc_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .idle_exec_i(idle_exec_i), .wake_i(wake_i), .idle_req_o(idle_req_o),
    .idle_ack_i(idle_ack_i), .periph_idle_req_o(periph_idle_req_o), .bus_err_o(bus_err_o));
  idc_dom_model i_idc_dom_model (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .req_i(idle_req_o), .ack_o(idle_ack_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobe order: write, read, idle, wake; one cycle each
  task automatic op(input logic [3:0] s, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {wr_i, rd_i, idle_exec_i, wake_i} <= s;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    {wr_i, rd_i, idle_exec_i, wake_i} <= 4'h0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
    op(4'h4, a, 16'h0000);
    chk(n, e, rdata_o);
  endtask
  task automatic dom(input logic [15:0] c, input logic e);
    logic [15:0] q;
    q = e ? 16'h0000 : (c & 16'h01ff);
    op(4'h8, IDC_ADDR_CFG, c);
    op(4'h2, 16'h0000, 16'h0000);
    chk("bus err", {15'h0, e}, {15'h0, bus_err_o});
    chk("req", q, 16'(idle_req_o));
    chk("periph", q[3] ? 16'h2005 : 16'h0000, 16'(periph_idle_req_o));
    repeat (3) @(posedge clk_i);
    rd(IDC_ADDR_STAT, q, "stat");
    op(4'h1, 16'h0000, 16'h0000);
    chk("woken", 16'h0000, 16'(idle_req_o));
    rd(IDC_ADDR_STAT, 16'h0000, "stat woken");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(IDC_ADDR_CFG, 16'h0000, "cfg reset");
    rd(IDC_ADDR_STAT, 16'h0000, "stat reset");
    rd(16'h0004, 16'h0000, "unmapped");
    op(4'h8, IDC_ADDR_CFG, 16'hffff);
    rd(IDC_ADDR_CFG, 16'h03ff, "cfg rw");
    op(4'h8, IDC_ADDR_STAT, 16'hffff);
    rd(IDC_ADDR_STAT, 16'h0000, "stat ro");
    chk("req before idle", 16'h0000, 16'(idle_req_o));
    // A write with the clock enable low must be lost
    @(posedge clk_i) ce_i <= 1'b0;
    op(4'h8, IDC_ADDR_CFG, 16'h0001);
    @(posedge clk_i) ce_i <= 1'b1;
    rd(IDC_ADDR_CFG, 16'h03ff, "cfg frozen");
    op(4'h8, IDC_ADDR_PSEL, 16'h2005);
    rd(IDC_ADDR_PSEL, 16'h2005, "psel rw");
    // Single domains; clock bit alone lacks its companions
    for (int b = 0; b < 9; b++) begin
      slow <= b[0];
      dom(16'h0001 << b, b == 4);
    end
    dom(16'h03ff, 1'b0);
    for (int b = 0; b < 10; b++) begin
      if (b != 3 && b != 4) begin
        dom(16'h03ff & ~(16'h0001 << b), 1'b1);
      end
    end
    // Idle and wake together: idle wins; then idle with peripheral bit clear
    op(4'h8, IDC_ADDR_CFG, 16'h0008);
    op(4'h3, 16'h0000, 16'h0000);
    chk("idle beats wake", 16'h2005, 16'(periph_idle_req_o));
    op(4'h8, IDC_ADDR_CFG, 16'h0000);
    op(4'h2, 16'h0000, 16'h0000);
    chk("periph released", 16'h0000, 16'(periph_idle_req_o));
    finish_test();
  end
  // Several times the expected run length
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule

// ===== verilog/idc_ctrl.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module idc_ctrl
  import idc_pkg::*;
#(
  parameter int NPERIPH = 14
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic idle_exec_i,
  input wire logic wake_i,
  output logic [IDC_NDOM-1:0] idle_req_o,
  input wire logic [IDC_NDOM-1:0] idle_ack_i,
  output logic [NPERIPH-1:0] periph_idle_req_o,
  output logic bus_err_o
);

  initial begin
    if (NPERIPH < 1 || NPERIPH > 16) begin
      $error("NPERIPH must be 1 to 16");
    end
  end

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] psel;
    logic [IDC_NDOM-1:0] req;
    logic [NPERIPH-1:0] preq;
    logic [IDC_NDOM-1:0] stat;
    logic err;
    logic [15:0] rdata;
  } idc_state_t;

  idc_state_t s_q;
  idc_state_t s_d;
  logic clk_bad;

  ////////////////////////////////////////////////////////////////////////
  // Clock idle legality
  always_comb begin
    clk_bad = s_q.cfg[IDC_B_CLK] &&
              ((s_q.cfg & IDC_CLK_REQ_MASK) != IDC_CLK_REQ_MASK);
  end

  always_comb begin
    s_d = s_q;
    s_d.err = 1'b0;
    if (wr_i && addr_i == IDC_ADDR_CFG) begin
      s_d.cfg = wdata_i & IDC_CFG_MASK;
    end
    if (wr_i && addr_i == IDC_ADDR_PSEL) begin
      s_d.psel = wdata_i;
    end
    if (idle_exec_i) begin
      if (clk_bad) begin
        s_d.err = 1'b1;
      end else begin
        s_d.req = s_q.cfg[IDC_NDOM-1:0];
        s_d.preq = s_q.cfg[IDC_B_PERIPH_GROUP_IDLE_CTL] ? s_q.psel[NPERIPH-1:0] : '0;
      end
    end else if (wake_i) begin
      s_d.req = '0;
      s_d.preq = '0;
    end
    s_d.stat = idle_ack_i & s_q.req;
    if (rd_i) begin
      unique case (addr_i)
        IDC_ADDR_CFG: s_d.rdata = s_q.cfg;
        IDC_ADDR_STAT: s_d.rdata = {7'h00, s_q.stat};
        IDC_ADDR_PSEL: s_d.rdata = s_q.psel;
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_q <= '{cfg: IDC_CFG_RST, psel: IDC_PSEL_RST, req: '0, preq: '0,
               stat: IDC_STAT_RST[IDC_NDOM-1:0], err: 1'b0, rdata: 16'h0000};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign idle_req_o = s_q.req;
  assign periph_idle_req_o = s_q.preq;
  assign bus_err_o = s_q.err;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Idle taken with a legal clock setup
  sequence idle_ok_s;
    ce_i && idle_exec_i && !clk_bad;
  endsequence

  // Idle refused for an illegal clock setup
  sequence idle_bad_s;
    ce_i && idle_exec_i && clk_bad;
  endsequence

  // Wake alone; an idle in the same cycle wins
  sequence wake_s;
    ce_i && wake_i && !idle_exec_i;
  endsequence

  // No idle and no wake: requests must hold
  sequence quiet_s;
    ce_i && !idle_exec_i && !wake_i;
  endsequence

  // Configuration write
  sequence cfg_wr_s;
    ce_i && wr_i && addr_i == IDC_ADDR_CFG;
  endsequence

  // Write aimed at the read-only status word
  sequence stat_wr_s;
    ce_i && wr_i && addr_i == IDC_ADDR_STAT;
  endsequence

  // Reads of configuration and status
  sequence cfg_rd_s;
    ce_i && rd_i && addr_i == IDC_ADDR_CFG;
  endsequence

  sequence stat_rd_s;
    ce_i && rd_i && addr_i == IDC_ADDR_STAT;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Requests per domain

  cpu_idle_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_CPU] == $past(s_q.cfg[IDC_B_CPU]))
    else $error("cpu request wrong");

  mp_idle_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_MP] == $past(s_q.cfg[IDC_B_MP]))
    else $error("dma host request wrong");

  cache_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_CACHE] == $past(s_q.cfg[IDC_B_CACHE]))
    else $error("cache request wrong");

  periph_group_idle_ctl_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_PERIPH_GROUP_IDLE_CTL] == $past(s_q.cfg[IDC_B_PERIPH_GROUP_IDLE_CTL]))
    else $error("peripheral group request wrong");

  clk_stop_a: assert property (
    (idle_ok_s and s_q.cfg[IDC_B_CLK]) |=> idle_req_o[IDC_B_CLK])
    else $error("clock generator not stopped");

  // Clock generator must keep running when its bit is clear
  clk_keep_a: assert property (
    (idle_ok_s and !s_q.cfg[IDC_B_CLK]) |=> !idle_req_o[IDC_B_CLK])
    else $error("clock generator stopped unasked");

  ext_memory_interface_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_EXT_MEMORY_INTERFACE] == $past(s_q.cfg[IDC_B_EXT_MEMORY_INTERFACE]))
    else $error("memory request wrong");

  io_memory_port_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_IO_MEMORY_PORT] == $past(s_q.cfg[IDC_B_IO_MEMORY_PORT]))
    else $error("io port request wrong");

  dma_host_port_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_DMA_HOST_PORT] == $past(s_q.cfg[IDC_B_DMA_HOST_PORT]))
    else $error("master port request wrong");

  instr_fetch_port_req_a: assert property (
    idle_ok_s |=> idle_req_o[IDC_B_INSTR_FETCH_PORT] == $past(s_q.cfg[IDC_B_INSTR_FETCH_PORT]))
    else $error("fetch port request wrong");

  periph_sel_a: assert property (
    (idle_ok_s and !s_q.cfg[IDC_B_PERIPH_GROUP_IDLE_CTL]) |=> periph_idle_req_o == '0)
    else $error("peripherals not woken");

  periph_pick_a: assert property (
    (idle_ok_s and s_q.cfg[IDC_B_PERIPH_GROUP_IDLE_CTL]) |=> periph_idle_req_o == $past(s_q.psel[NPERIPH-1:0]))
    else $error("peripheral selection wrong");

  wake_clear_a: assert property (
    wake_s |=> idle_req_o == '0 && periph_idle_req_o == '0)
    else $error("wake left requests");

  // Requests are levels; they must not drift between commands
  req_hold_a: assert property (
    quiet_s |=> $stable(idle_req_o) && $stable(periph_idle_req_o))
    else $error("requests moved without command");

  idle_wins_a: assert property (
    ce_i && idle_exec_i && wake_i && !clk_bad |=> idle_req_o == $past(s_q.cfg[IDC_NDOM-1:0]))
    else $error("wake beat idle");

  // Writing the configuration alone must not touch any domain
  cfg_quiet_a: assert property (
    (cfg_wr_s and quiet_s) |=> $stable(idle_req_o))
    else $error("configuration acted early");

  ////////////////////////////////////////////////////////////////////////
  // Clock generator legality

  clk_err_a: assert property (
    ce_i && idle_exec_i && s_q.cfg[IDC_B_CLK] && !s_q.cfg[IDC_B_CLKE] |=> bus_err_o)
    else $error("missing bus error");

  clk_all_a: assert property (
    idle_bad_s |=> bus_err_o && $stable(idle_req_o))
    else $error("clock idle not refused");

  err_cause_a: assert property (
    bus_err_o |-> $past(ce_i && idle_exec_i && clk_bad))
    else $error("bus error without cause");

  // The error is a pulse; a stuck flag would raise repeated interrupts
  err_quiet_a: assert property (
    quiet_s |=> !bus_err_o)
    else $error("bus error without idle");

  ok_no_err_a: assert property (
    idle_ok_s |=> !bus_err_o)
    else $error("bus error on legal idle");

  ////////////////////////////////////////////////////////////////////////
  // Status

  fetch_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_INSTR_FETCH_PORT] == $past(idle_ack_i[IDC_B_INSTR_FETCH_PORT] && s_q.req[IDC_B_INSTR_FETCH_PORT]))
    else $error("fetch port status wrong");

  dma_host_port_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_DMA_HOST_PORT] == $past(idle_ack_i[IDC_B_DMA_HOST_PORT] && s_q.req[IDC_B_DMA_HOST_PORT]))
    else $error("master port status wrong");

  io_memory_port_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_IO_MEMORY_PORT] == $past(idle_ack_i[IDC_B_IO_MEMORY_PORT] && s_q.req[IDC_B_IO_MEMORY_PORT]))
    else $error("io port status wrong");

  ext_memory_interface_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_EXT_MEMORY_INTERFACE] == $past(idle_ack_i[IDC_B_EXT_MEMORY_INTERFACE] && s_q.req[IDC_B_EXT_MEMORY_INTERFACE]))
    else $error("memory status wrong");

  clk_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_CLK] == $past(idle_ack_i[IDC_B_CLK] && s_q.req[IDC_B_CLK]))
    else $error("clock generator status wrong");

  periph_group_idle_ctl_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_PERIPH_GROUP_IDLE_CTL] == $past(idle_ack_i[IDC_B_PERIPH_GROUP_IDLE_CTL] && s_q.req[IDC_B_PERIPH_GROUP_IDLE_CTL]))
    else $error("peripheral group status wrong");

  cache_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_CACHE] == $past(idle_ack_i[IDC_B_CACHE] && s_q.req[IDC_B_CACHE]))
    else $error("cache status wrong");

  mp_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_MP] == $past(idle_ack_i[IDC_B_MP] && s_q.req[IDC_B_MP]))
    else $error("dma host status wrong");

  cpu_stat_a: assert property (
    ce_i |=> s_q.stat[IDC_B_CPU] == $past(idle_ack_i[IDC_B_CPU] && s_q.req[IDC_B_CPU]))
    else $error("cpu status wrong");

  // Read answer must carry the status of the read cycle itself
  stat_track_a: assert property (
    ce_i ##1 stat_rd_s
    |=> rdata_o[8:0] == $past(s_q.stat))
    else $error("status read wrong");

  stat_cause_a: assert property (
    s_q.stat != '0 |-> $past(s_q.req) != '0)
    else $error("status without request");

  stat_clear_a: assert property (
    ce_i && s_q.req == '0 |=> s_q.stat == '0)
    else $error("status stayed after wake");

  // Per domain: a status bit never stands without its request of the cycle before
  for (genvar g = 0; g < IDC_NDOM; g++) begin : g_dom_chk
    dom_stat_req_a: assert property (
      ce_i && !s_q.req[g] |=> !s_q.stat[g])
      else $error("domain status without request");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port and reset

  // Reserved bits read zero so software can compare whole words
  cfg_res_a: assert property (
    s_q.cfg[15:10] == 6'h00)
    else $error("reserved configuration bits set");

  cfg_wr_a: assert property (
    cfg_wr_s |=> s_q.cfg == $past(wdata_i & IDC_CFG_MASK))
    else $error("configuration write lost");

  ext_rw_a: assert property (
    cfg_wr_s |=> s_q.cfg[IDC_B_CLKE] == $past(wdata_i[IDC_B_CLKE]))
    else $error("extended bit not written");

  cfg_back_a: assert property (
    cfg_rd_s |=> rdata_o == $past(s_q.cfg))
    else $error("configuration read wrong");

  stat_res_a: assert property (
    stat_rd_s |=> rdata_o[15:9] == 7'h00)
    else $error("reserved status bits set");

  stat_ro_a: assert property (
    stat_wr_s |=> $stable(s_q.cfg) && $stable(s_q.psel))
    else $error("status write had an effect");

  // Clock enable low must freeze every bit of state
  ce_freeze_a: assert property (
    !ce_i |=> $stable(s_q))
    else $error("state moved while disabled");

  reset_zero_a: assert property (@(posedge clk_i) disable iff (1'b0)
    !rstn_i |=> s_q.cfg == '0 && s_q.stat == '0 && idle_req_o == '0
    && !bus_err_o)
    else $error("reset value wrong");

endmodule

// ===== verilog/idc_pkg.sv
package idc_pkg;
  // Register indices, word addressed on the plain port
  localparam logic [15:0] IDC_ADDR_CFG = 16'h0001;
  localparam logic [15:0] IDC_ADDR_STAT = 16'h0002;
  localparam logic [15:0] IDC_ADDR_PSEL = 16'h0003;
  localparam logic [15:0] IDC_CFG_RST = 16'h0000;
  localparam logic [15:0] IDC_STAT_RST = 16'h0000;
  localparam logic [15:0] IDC_PSEL_RST = 16'h0000;
  localparam logic [15:0] IDC_CFG_MASK = 16'h03ff;
  localparam logic [15:0] IDC_STAT_MASK = 16'h01ff;
  // Field positions shared by configuration and status, except IDC_B_CLKE in configuration only
  localparam int IDC_B_CPU = 0;
  localparam int IDC_B_MP = 1;
  localparam int IDC_B_CACHE = 2;
  localparam int IDC_B_PERIPH_GROUP_IDLE_CTL = 3;
  localparam int IDC_B_CLK = 4;
  localparam int IDC_B_EXT_MEMORY_INTERFACE = 5;
  localparam int IDC_B_IO_MEMORY_PORT = 6;
  localparam int IDC_B_DMA_HOST_PORT = 7;
  localparam int IDC_B_INSTR_FETCH_PORT = 8;
  localparam int IDC_B_CLKE = 9;
  localparam int IDC_NDOM = 9;
  // Bits that must all be set when the clock generator is idled
  localparam logic [15:0] IDC_CLK_REQ_MASK = 16'h03e7;
endpackage
